/* fiml_fault_latch.sv */
`timescale 1ns/1ps

module fiml_fault_latch
    import fiml_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic [3:0] sys_event_live,
    input  wire logic [3:0] sys_event_mask,
    input  wire logic [7:0] ch1_fault_live,
    input  wire logic [7:0] ch2_fault_live,
    input  wire logic       vbat_low_short_live,
    input  wire logic       clear_on_read_select,
    input  wire logic       latch_readback_select,
    output logic      [7:0] channel_dc_fault_mask_q,
    output logic      [7:0] diag_fault_mask_q,
    output logic            irq_out
);

    logic [7:0] channel_dc_fault_mask_reg;
    logic [7:0] diag_fault_mask_reg;
    logic [1:0] ch_sum_reg;
    logic [1:0] ch_sum_next;
    logic [7:0] reg_rdata_reg;
    logic       reg_rvalid_reg;

    logic       rd_sys;
    logic       rd_sum;
    logic [1:0] rd_ch;
    logic [3:0] sys_q;
    logic [3:0] sys_set;
    logic [3:0] sys_unm;
    logic       vbat_q;
    logic       vbat_set;
    logic       vbat_unm;
    logic [7:0] ch_live  [FIML_NUM_CH];
    logic [7:0] ch_q     [FIML_NUM_CH];
    logic [7:0] ch_set   [FIML_NUM_CH];
    logic [7:0] ch_unm   [FIML_NUM_CH];
    logic [1:0] ch_gate;
    logic [1:0] ch_sum_vis;
    logic [7:0] sys_view;
    logic [7:0] sum_view;
    logic [7:0] ch1_view;
    logic [7:0] ch2_view;
    logic [7:0] rd_mux;

    // Read strobes that clear sticky bits; the read itself sees pre-clear data
    assign rd_sys   = reg_rd & fiml_hit(reg_addr, FIML_OFF_SYS_LATCH);
    assign rd_sum   = reg_rd & fiml_hit(reg_addr, FIML_OFF_SUMMARY);
    assign rd_ch[0] = reg_rd & fiml_hit(reg_addr, FIML_OFF_CH1_LATCH);
    assign rd_ch[1] = reg_rd & fiml_hit(reg_addr, FIML_OFF_CH2_LATCH);

    // Channel input DC fault mask; reserved bits are stored as written
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_dc_fault_mask_reg <= FIML_RST_DC_MASK;
        end else if (reg_wr && fiml_hit(reg_addr, FIML_OFF_DC_MASK)) begin
            channel_dc_fault_mask_reg <= reg_wdata;
        end
    end

    // Diagnostic fault mask, one bit per fault type shared by both channels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            diag_fault_mask_reg <= FIML_RST_DIAG_MASK;
        end else if (reg_wr && fiml_hit(reg_addr, FIML_OFF_DIAG_MASK)) begin
            diag_fault_mask_reg <= reg_wdata;
        end
    end

    assign channel_dc_fault_mask_q = channel_dc_fault_mask_reg;
    assign diag_fault_mask_q       = diag_fault_mask_reg;

    // System events: clock error, PLL lock, over-temperature, over-current
    fiml_latch_cell #(
        .W(FIML_SYS_WIDTH)
    ) u_sys_latch (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .live       (sys_event_live),
        .rd_clr     (rd_sys),
        .clr_always (clear_on_read_select),
        .latch_q    (sys_q),
        .set_evt    (sys_set)
    );

    // Battery short while battery sits below the bias supply
    fiml_latch_cell #(
        .W(1)
    ) u_vbat_latch (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .live       (vbat_low_short_live),
        .rd_clr     (rd_sum),
        .clr_always (clear_on_read_select),
        .latch_q    (vbat_q),
        .set_evt    (vbat_set)
    );

    assign ch_live[0] = ch1_fault_live;
    assign ch_live[1] = ch2_fault_live;

    // Channel enable for interrupts: bit 7 gates channel 1, bit 6 channel 2
    assign ch_gate[0] = ~channel_dc_fault_mask_reg[FIML_DC_CH1_BIT];
    assign ch_gate[1] = ~channel_dc_fault_mask_reg[FIML_DC_CH2_BIT];

    // Per-channel detail latches and their summary bits
    for (genvar c = 0; c < FIML_NUM_CH; c++) begin : g_ch
        fiml_latch_cell #(
            .W(8)
        ) u_detail (
            .sys_clk    (sys_clk),
            .rst_n      (rst_n),
            .live       (ch_live[c]),
            .rd_clr     (rd_ch[c]),
            .clr_always (clear_on_read_select),
            .latch_q    (ch_q[c]),
            .set_evt    (ch_set[c])
        );

        // Each diagnostic mask bit masks the same fault position in both channels
        assign ch_unm[c] = ch_q[c] & ~diag_fault_mask_reg & {8{ch_gate[c]}};

        // Summary follows any detail set in the same cycle; set beats the read clear
        always_comb begin
            ch_sum_next[c] = ch_sum_reg[c];
            if (rd_sum && (clear_on_read_select || !(|ch_live[c]))) begin
                ch_sum_next[c] = 1'b0;
            end
            if (|ch_set[c]) begin
                ch_sum_next[c] = 1'b1;
            end
        end

        // Summary hidden when the whole channel is masked and readback is filtered
        assign ch_sum_vis[c] = ch_sum_reg[c] & (ch_gate[c] | ~latch_readback_select);
    end

    // Summary flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_sum_reg <= '0;
        end else begin
            ch_sum_reg <= ch_sum_next;
        end
    end

    // Unmasked system events and battery-low short
    assign sys_unm  = sys_q & ~sys_event_mask;
    assign vbat_unm = vbat_q & ~(diag_fault_mask_reg[FIML_DIAG_VBAT_P_BIT]
                               & diag_fault_mask_reg[FIML_DIAG_VBAT_M_BIT]);

    // Readback views; filtered option hides masked bits, reserved bits read zero
    assign sys_view = {(latch_readback_select ? sys_unm : sys_q), 4'h0};
    assign ch1_view = latch_readback_select ? ch_unm[0] : ch_q[0];
    assign ch2_view = latch_readback_select ? ch_unm[1] : ch_q[1];

    // Summary layout: bits 7, 6, 1 live, the rest reserved zero
    always_comb begin
        sum_view = FIML_RST_LATCH;
        sum_view[FIML_SUM_CH1_BIT]  = ch_sum_vis[0];
        sum_view[FIML_SUM_CH2_BIT]  = ch_sum_vis[1];
        sum_view[FIML_SUM_VBAT_BIT] = latch_readback_select ? vbat_unm : vbat_q;
    end

    // Read mux; unmapped offsets answer zero
    always_comb begin
        case (reg_addr)
            FIML_OFF_DC_MASK: begin
                rd_mux = channel_dc_fault_mask_reg;
            end
            FIML_OFF_DIAG_MASK: begin
                rd_mux = diag_fault_mask_reg;
            end
            FIML_OFF_SYS_LATCH: begin
                rd_mux = sys_view;
            end
            FIML_OFF_SUMMARY: begin
                rd_mux = sum_view;
            end
            FIML_OFF_CH1_LATCH: begin
                rd_mux = ch1_view;
            end
            FIML_OFF_CH2_LATCH: begin
                rd_mux = ch2_view;
            end
            default: begin
                rd_mux = FIML_RDATA_UNMAPPED;
            end
        endcase
    end

    // Read data is captured at the strobe edge, before the clear lands
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_reg <= FIML_RDATA_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata_reg <= rd_mux;
        end
    end

    // One-cycle answer marker
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rvalid_reg <= reg_rd;
        end
    end

    assign reg_rdata  = reg_rdata_reg;
    assign reg_rvalid = reg_rvalid_reg;

    // Level event mode: masks gate the output regardless of readback filtering
    assign irq_out = (|sys_unm) | (|ch_unm[0]) | (|ch_unm[1]) | vbat_unm;

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_ch1_gate;
        (channel_dc_fault_mask_reg[FIML_DC_CH1_BIT] && ch_q[1] == 8'h00 &&
         sys_unm == 4'h0 && !vbat_unm) |-> !irq_out;
    endproperty
    a_ch1_gate: assert property (p_ch1_gate)
        else $error("channel 1 fault reached irq while masked");

    property p_ch2_gate;
        (channel_dc_fault_mask_reg[FIML_DC_CH2_BIT] && ch_q[0] == 8'h00 &&
         sys_unm == 4'h0 && !vbat_unm) |-> !irq_out;
    endproperty
    a_ch2_gate: assert property (p_ch2_gate)
        else $error("channel 2 fault reached irq while masked");

    property p_diag_all_masked;
        (diag_fault_mask_reg == 8'hFF && sys_unm == 4'h0) |-> !irq_out;
    endproperty
    a_diag_all_masked: assert property (p_diag_all_masked)
        else $error("diagnostic fault reached irq with all masks set");

    property p_diag_rw;
        (reg_wr && fiml_hit(reg_addr, FIML_OFF_DIAG_MASK))
        ##1 !(reg_wr && fiml_hit(reg_addr, FIML_OFF_DIAG_MASK))
        ##1 (reg_rd && !reg_wr && fiml_hit(reg_addr, FIML_OFF_DIAG_MASK))
        |=> (reg_rvalid && reg_rdata == $past(reg_wdata, 3));
    endproperty
    a_diag_rw: assert property (p_diag_rw)
        else $error("diagnostic mask readback differs from write");

    property p_clkerr_latch;
        $rose(sys_event_live[3]) ##1 (reg_rd && fiml_hit(reg_addr, FIML_OFF_SYS_LATCH)
                                      && !latch_readback_select)
        |=> reg_rdata[7];
    endproperty
    a_clkerr_latch: assert property (p_clkerr_latch)
        else $error("clock error not seen in system latch bit 7");

    property p_pll_latch;
        $rose(sys_event_live[2]) ##1 (sys_q[2] && (!rd_sys ||
            (sys_event_live[2] && !clear_on_read_select))) |=> sys_q[2];
    endproperty
    a_pll_latch: assert property (p_pll_latch)
        else $error("PLL lock latch lost without a clearing read");

    property p_sys_reserved;
        reg_rvalid && $past(fiml_hit(reg_addr, FIML_OFF_SYS_LATCH)) |-> reg_rdata[3:0] == 4'h0;
    endproperty
    a_sys_reserved: assert property (p_sys_reserved)
        else $error("system latch reserved bits not zero");

    property p_sum_follow;
        (|ch_set[0]) |=> ch_sum_reg[0];
    endproperty
    a_sum_follow: assert property (p_sum_follow)
        else $error("channel 1 summary missed a detail set");

    property p_edge_clear;
        (clear_on_read_select && rd_sys && sys_set == 4'h0) |=> sys_q == 4'h0;
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("edge mode read did not clear system latch");

    property p_irq_on_event;
        ($rose(sys_event_live[0]) && !sys_event_mask[0]) |=> irq_out;
    endproperty
    a_irq_on_event: assert property (p_irq_on_event)
        else $error("unmasked over-current did not raise irq");

    property p_ch2_sum;
        (|ch_set[1]) |=> ch_sum_reg[1];
    endproperty
    a_ch2_sum: assert property (p_ch2_sum)
        else $error("channel 2 summary missed a detail set");

    property p_vbat_set;
        vbat_set |=> vbat_q;
    endproperty
    a_vbat_set: assert property (p_vbat_set)
        else $error("battery short event not latched");

    property p_sum_reserved;
        reg_rvalid && $past(fiml_hit(reg_addr, FIML_OFF_SUMMARY))
        |-> (reg_rdata[5:2] == 4'h0 && !reg_rdata[0]);
    endproperty
    a_sum_reserved: assert property (p_sum_reserved)
        else $error("summary reserved bits not zero");

    property p_sys_filtered;
        reg_rvalid && $past(rd_sys && latch_readback_select)
        |-> (reg_rdata[7:4] & $past(sys_event_mask)) == 4'h0;
    endproperty
    a_sys_filtered: assert property (p_sys_filtered)
        else $error("masked system event shown in filtered readback");

    c_irq_raised:  cover property ($rose(irq_out));
    c_sum_cleared: cover property (ch_sum_reg[0] ##1 rd_sum ##1 !ch_sum_reg[0]);
    c_filtered:    cover property (latch_readback_select && sys_q != 4'h0 && sys_unm == 4'h0);
    c_vbat_latch:  cover property ($rose(vbat_q));

endmodule

/* fiml_latch_cell.sv */
`timescale 1ns/1ps

// Bank of sticky fault bits with the two clear-on-read behaviours
module fiml_latch_cell
    import fiml_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] live,
    input  wire logic         rd_clr,
    input  wire logic         clr_always,
    output logic      [W-1:0] latch_q,
    output logic      [W-1:0] set_evt
);

    logic [W-1:0] live_prev_reg;
    logic [W-1:0] latch_reg;
    logic [W-1:0] latch_next;
    logic [W-1:0] clr_vec;

    // Edge mode sets only on a fresh rise, level mode while live is high
    assign set_evt = clr_always ? (live & ~live_prev_reg) : live;

    // Level mode must not drop a fault that is still present
    assign clr_vec = rd_clr ? (clr_always ? {W{1'b1}} : ~live) : '0;

    // Set wins over a clear in the same cycle
    assign latch_next = set_evt | (latch_reg & ~clr_vec);

    // Previous live level for rise detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            live_prev_reg <= '0;
        end else begin
            live_prev_reg <= live;
        end
    end

    // Sticky bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= '0;
        end else begin
            latch_reg <= latch_next;
        end
    end

    assign latch_q = latch_reg;

endmodule

/* fiml_pkg.sv */
package fiml_pkg;

    // Register offsets on the device register port
    localparam logic [7:0] FIML_OFF_DC_MASK   = 8'h2A;
    localparam logic [7:0] FIML_OFF_DIAG_MASK = 8'h2B;
    localparam logic [7:0] FIML_OFF_SYS_LATCH = 8'h2C;
    localparam logic [7:0] FIML_OFF_SUMMARY   = 8'h2D;
    localparam logic [7:0] FIML_OFF_CH1_LATCH = 8'h2E;
    localparam logic [7:0] FIML_OFF_CH2_LATCH = 8'h2F;

    // Values after reset
    localparam logic [7:0] FIML_RST_DC_MASK   = 8'h03;
    localparam logic [7:0] FIML_RST_DIAG_MASK = 8'h00;
    localparam logic [7:0] FIML_RST_LATCH     = 8'h00;
    localparam logic [7:0] FIML_RDATA_UNMAPPED = 8'h00;

    // Field positions in the channel input DC fault mask register
    localparam int FIML_DC_CH1_BIT = 7;
    localparam int FIML_DC_CH2_BIT = 6;

    // System latch fields sit in bits 7..4; bits 3..0 read as zero
    localparam int FIML_SYS_LSB    = 4;
    localparam int FIML_SYS_WIDTH  = 4;

    // Channel summary field positions
    localparam int FIML_SUM_CH1_BIT  = 7;
    localparam int FIML_SUM_CH2_BIT  = 6;
    localparam int FIML_SUM_VBAT_BIT = 1;

    // Diagnostic mask bits for the two short-to-battery faults
    localparam int FIML_DIAG_VBAT_P_BIT = 1;
    localparam int FIML_DIAG_VBAT_M_BIT = 0;

    localparam int FIML_NUM_CH = 2;

    // Address match, used by every strobe decode
    function automatic logic fiml_hit(input logic [7:0] addr, input logic [7:0] off);
        fiml_hit = (addr == off);
    endfunction

endpackage

/* tb.sv */
`timescale 1ns/1ps

module tb;
    import fiml_pkg::*;

    logic       sys_clk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic [3:0] sys_event_live;
    logic [3:0] sys_event_mask;
    logic [7:0] ch1_fault_live;
    logic [7:0] ch2_fault_live;
    logic       vbat_low_short_live;
    logic       clear_on_read_select;
    logic       latch_readback_select;
    logic [7:0] channel_dc_fault_mask_q;
    logic [7:0] diag_fault_mask_q;
    logic       irq_out;
    int         fails;
    int         num_checks;
    int         cycles;
    logic [7:0] d;
    logic [7:0] r;
    int         k;

    fiml_fault_latch dut_u (
        .sys_clk                 (sys_clk),
        .rst_n                   (rst_n),
        .reg_addr                (reg_addr),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_wdata               (reg_wdata),
        .reg_rdata               (reg_rdata),
        .reg_rvalid              (reg_rvalid),
        .sys_event_live          (sys_event_live),
        .sys_event_mask          (sys_event_mask),
        .ch1_fault_live          (ch1_fault_live),
        .ch2_fault_live          (ch2_fault_live),
        .vbat_low_short_live     (vbat_low_short_live),
        .clear_on_read_select    (clear_on_read_select),
        .latch_readback_select   (latch_readback_select),
        .channel_dc_fault_mask_q (channel_dc_fault_mask_q),
        .diag_fault_mask_q       (diag_fault_mask_q),
        .irq_out                 (irq_out)
    );

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // Expected one-hot value for a field position
    function automatic logic [7:0] bit_of(input int n);
        return 8'h01 << n;
    endfunction

    task automatic end_of_test();
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bus cycles start on a falling edge; the rising edge between takes them
    // An idle cycle follows so a second call never re-raises a strobe at once
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        @(negedge sys_clk);
    endtask

    // Read data is looked at in the one cycle that rvalid stands
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        chk({7'h00, reg_rvalid}, 8'h01);
        v = reg_rdata;
        @(negedge sys_clk);
        chk({7'h00, reg_rvalid}, 8'h00);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v, e);
    endtask

    // One-cycle live pulse; live inputs return low afterwards
    task automatic pulse(input logic [3:0] s, input logic [7:0] c1, input logic [7:0] c2,
                         input logic v);
        sys_event_live      = s;
        ch1_fault_live      = c1;
        ch2_fault_live      = c2;
        vbat_low_short_live = v;
        @(negedge sys_clk);
        sys_event_live      = 4'h0;
        ch1_fault_live      = 8'h00;
        ch2_fault_live      = 8'h00;
        vbat_low_short_live = 1'b0;
    endtask

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        {sys_clk, rst_n, reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
        {sys_event_live, sys_event_mask, ch1_fault_live, ch2_fault_live} = '0;
        {vbat_low_short_live, clear_on_read_select, latch_readback_select} = '0;
        void'($urandom(91795));
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        chk(channel_dc_fault_mask_q, FIML_RST_DC_MASK);
        rchk(FIML_OFF_DC_MASK, 8'h03);
        rchk(FIML_OFF_DIAG_MASK, 8'h00);
        rchk(FIML_OFF_SYS_LATCH, 8'h00);
        rchk(FIML_OFF_SUMMARY, 8'h00);
        rchk(8'h10, FIML_RDATA_UNMAPPED);
        for (k = 0; k < 16; k++) begin
            d = 8'($urandom());
            wr(FIML_OFF_DIAG_MASK, d);
            chk(diag_fault_mask_q, d);
            rchk(FIML_OFF_DIAG_MASK, d);
            r = {d[7:6], 6'h03};
            wr(FIML_OFF_DC_MASK, r);
            rchk(FIML_OFF_DC_MASK, r);
            wr(FIML_OFF_SYS_LATCH, d);
            wr(FIML_OFF_SUMMARY, d);
            rchk(FIML_OFF_SYS_LATCH, 8'h00);
            rchk(FIML_OFF_SUMMARY, 8'h00);
        end
        wr(FIML_OFF_DIAG_MASK, 8'h00);
        wr(FIML_OFF_DC_MASK, 8'h03);
        // Each system event latches into its own bit and clears on read
        for (k = 0; k < 4; k++) begin
            pulse(4'(bit_of(k)), 8'h00, 8'h00, 1'b0);
            chk({7'h00, irq_out}, 8'h01);
            rchk(FIML_OFF_SYS_LATCH, bit_of(FIML_SYS_LSB + k));
            chk({7'h00, irq_out}, 8'h00);
            rchk(FIML_OFF_SYS_LATCH, 8'h00);
        end
        // Masked event stays readable but raises nothing; filtered readback hides it
        sys_event_mask = 4'h8;
        pulse(4'h8, 8'h00, 8'h00, 1'b0);
        chk({7'h00, irq_out}, 8'h00);
        rchk(FIML_OFF_SYS_LATCH, 8'h80);
        latch_readback_select = 1'b1;
        pulse(4'h8, 8'h00, 8'h00, 1'b0);
        rchk(FIML_OFF_SYS_LATCH, 8'h00);
        latch_readback_select = 1'b0;
        sys_event_mask        = 4'h0;
        rd(FIML_OFF_SYS_LATCH, d);
        rchk(FIML_OFF_SYS_LATCH, 8'h00);
        // Mode 0: a read with live still high keeps the bit
        sys_event_live = 4'h4;
        @(negedge sys_clk);
        rchk(FIML_OFF_SYS_LATCH, 8'h40);
        rchk(FIML_OFF_SYS_LATCH, 8'h40);
        sys_event_live = 4'h0;
        rchk(FIML_OFF_SYS_LATCH, 8'h40);
        rchk(FIML_OFF_SYS_LATCH, 8'h00);
        // Mode 1: cleared even while high, not set again without a new rise
        clear_on_read_select = 1'b1;
        sys_event_live       = 4'h1;
        @(negedge sys_clk);
        rchk(FIML_OFF_SYS_LATCH, 8'h10);
        rchk(FIML_OFF_SYS_LATCH, 8'h00);
        // The first pulse below drops the live event in this same step
        clear_on_read_select = 1'b0;
        // Every diagnostic fault type, unmasked on channel 1 and masked on channel 2
        for (k = 0; k < 8; k++) begin
            pulse(4'h0, bit_of(k), 8'h00, 1'b0);
            chk({7'h00, irq_out}, 8'h01);
            rchk(FIML_OFF_SUMMARY, 8'h80);
            rchk(FIML_OFF_CH1_LATCH, bit_of(k));
            chk({7'h00, irq_out}, 8'h00);
            wr(FIML_OFF_DIAG_MASK, bit_of(k));
            pulse(4'h0, 8'h00, bit_of(k), 1'b0);
            chk({7'h00, irq_out}, 8'h00);
            rchk(FIML_OFF_SUMMARY, 8'h40);
            rchk(FIML_OFF_CH2_LATCH, bit_of(k));
            wr(FIML_OFF_DIAG_MASK, 8'h00);
        end
        // Channel DC masks gate the whole channel
        wr(FIML_OFF_DC_MASK, 8'h83);
        pulse(4'h0, bit_of(7), 8'h00, 1'b0);
        chk({7'h00, irq_out}, 8'h00);
        rchk(FIML_OFF_SUMMARY, 8'h80);
        rd(FIML_OFF_CH1_LATCH, d);
        wr(FIML_OFF_DC_MASK, 8'h43);
        pulse(4'h0, 8'h00, bit_of(5), 1'b0);
        chk({7'h00, irq_out}, 8'h00);
        latch_readback_select = 1'b1;
        rchk(FIML_OFF_SUMMARY, 8'h00);
        latch_readback_select = 1'b0;
        rd(FIML_OFF_SUMMARY, d);
        rd(FIML_OFF_CH2_LATCH, d);
        wr(FIML_OFF_DC_MASK, 8'h03);
        // Filtered readback hides a masked detail bit but keeps the unmasked one
        wr(FIML_OFF_DIAG_MASK, 8'h80);
        pulse(4'h0, 8'h81, 8'h00, 1'b0);
        chk({7'h00, irq_out}, 8'h01);
        latch_readback_select = 1'b1;
        rchk(FIML_OFF_CH1_LATCH, 8'h01);
        latch_readback_select = 1'b0;
        wr(FIML_OFF_DIAG_MASK, 8'h00);
        rchk(FIML_OFF_SUMMARY, 8'h80);
        // Battery short below bias voltage
        pulse(4'h0, 8'h00, 8'h00, 1'b1);
        chk({7'h00, irq_out}, 8'h01);
        rchk(FIML_OFF_SUMMARY, 8'h02);
        rchk(FIML_OFF_SUMMARY, 8'h00);
        end_of_test();
    end
endmodule
